// ---- pkg/chain_pkg.sv ----
// Constants, field layouts and carrier types for the operation-data chain sequencer.
// Assumes one 40 MHz clock; the profile generator and entry store sit outside.
//
// Notes on behaviour
// R01 - Automatic chaining: hold stopped for entry's delay, then start its next entry.
// R02 - Finishing an entry whose link is none ends the chain and stops the motor.
// R03 - Start with servo on and ready high: drop ready, raise busy, run selected entry.
// R04 - Host: servo on, see ready, select entry, pulse start until ready falls.
// R05 - After the whole chain completes, clear busy and raise ready again.
// R06 - Continuous chaining hands over to the next entry without stopping.
// R07 - Continuous: at target, switch entry and ramp from present to new speed.
// R08 - Acceleration into the next entry uses that next entry's changing rate.
// R09 - Reverse direction in the next entry decelerates with its stopping rate.
// R10 - Final stop uses the stopping deceleration of the last executed entry.
// R11 - Reversal in continuous mode overshoots the previous target, decelerating after it.
// R12 - Link code: 0 none, 1 manual, 2 automatic, 3 continuous; resets to 0.
// R13 - Next number: -256 stop, -2 two ahead, -1 following, 0..255 explicit; reset -1.
// R14 - Delay is counted down per tick from the entry setting; next starts at zero.
// R15 - Selected entry number is latched when start is accepted.
package chain_pkg;

    localparam int ENTRY_W = 8;
    localparam int NEXT_W  = 10;
    localparam int RATE_W  = 16;
    localparam int DELAY_W = 24;

    // Delay setting is in milliseconds; one tick is one millisecond
    localparam int DELAY_TICK_NS  = 1000000;
    localparam int CLK_PERIOD_NS  = 25;
    localparam int TICK_CYCLES    = DELAY_TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W         = 16;

    typedef enum logic [1:0] {
        LINK_NONE   = 2'h0,
        LINK_MANUAL = 2'h1,
        LINK_AUTO   = 2'h2,
        LINK_CONT   = 2'h3
    } link_mode_t;

    localparam logic [NEXT_W-1:0] NEXT_STOP     = 10'h300; // -256
    localparam logic [NEXT_W-1:0] NEXT_PLUS_TWO = 10'h3fe; // -2
    localparam logic [NEXT_W-1:0] NEXT_PLUS_ONE = 10'h3ff; // -1
    localparam logic [1:0]        NEXT_STEP_ONE = 2'h1;
    localparam logic [1:0]        NEXT_STEP_TWO = 2'h2;

    // One operation data entry as the store returns it
    typedef struct packed {
        link_mode_t          link;
        logic [NEXT_W-1:0]   next_num;
        logic [DELAY_W-1:0]  delay;
        logic [RATE_W-1:0]   accel_rate;
        logic [RATE_W-1:0]   stop_rate;
        logic                reverse;
    } entry_t;

    localparam entry_t ENTRY_RESET = '{link: LINK_NONE, next_num: NEXT_PLUS_ONE,
                                       delay: '0, accel_rate: '0, stop_rate: '0,
                                       reverse: 1'b0};

    // Command to the profile generator
    typedef struct packed {
        logic                run;
        logic                launch;
        logic [ENTRY_W-1:0]  entry;
        logic [RATE_W-1:0]   rate;
        logic                decel;
    } motion_cmd_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_FETCH = 5'h02,
        ST_MOVE  = 5'h04,
        ST_DWELL = 5'h08,
        ST_STOP  = 5'h10
    } seq_state_t;

    // Next entry number; returns valid low for a stop or out-of-range code
    function automatic logic [ENTRY_W:0] next_entry(input logic [ENTRY_W-1:0] cur,
                                                    input logic [NEXT_W-1:0]  code);
        logic [ENTRY_W:0] r;
        r = '0;
        if (code == NEXT_PLUS_ONE)
            r = {1'b1, cur + ENTRY_W'(NEXT_STEP_ONE)};
        else if (code == NEXT_PLUS_TWO)
            r = {1'b1, cur + ENTRY_W'(NEXT_STEP_TWO)};
        else if (code[NEXT_W-1:ENTRY_W] == 2'h0)
            r = {1'b1, code[ENTRY_W-1:0]};
        return r;
    endfunction

endpackage

// ---- src/delay_tick_timer.sv ----
// Completion-delay timer: divides the clock into ticks and counts a load down.
// Assumes load and value come from the sequencer in the same clock domain.
`timescale 1ns/1ps
module delay_tick_timer
    import chain_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // Control
    input  wire logic               load,
    input  wire logic [DELAY_W-1:0] value,
    // Status
    output logic                    expired
);

    typedef struct packed {
        logic [TICK_W-1:0]  pre;
        logic [DELAY_W-1:0] cnt;
        logic               done;
    } tmr_state_t;

    tmr_state_t s_q;
    tmr_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (load)
        begin
            s_d.pre  = '0;
            s_d.cnt  = value;
            s_d.done = (value == '0);
        end
        else if (!s_q.done)
        begin
            if (s_q.pre == TICK_W'(TICK_CYCLES - 1))
            begin
                s_d.pre = '0;
                s_d.cnt = s_q.cnt - DELAY_W'(1); // see R14
                s_d.done = (s_q.cnt == DELAY_W'(1));
            end
            else
                s_d.pre = s_q.pre + TICK_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_q <= '{pre: '0, cnt: '0, done: 1'b1};
        else if (ce)
            s_q <= s_d;
    end

    assign expired = s_q.done;

    zero_at_end_a: assert property (@(posedge clk) disable iff (rst)
        ce && !load && s_q.done |=> s_q.cnt == '0) // see R14
        else $error("delay timer done with nonzero count");

endmodule

// ---- src/chain_sequencer.sv ----
// Operation-data chain sequencer: start handshake, automatic and continuous linking.
// Assumes the entry store answers entry_data one cycle after entry_addr and the
// profile generator reports op_done at the target (position or stop reached).
`timescale 1ns/1ps
module chain_sequencer
    import chain_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // Host handshake
    input  wire logic               servo_on,
    input  wire logic               start,
    input  wire logic [ENTRY_W-1:0] entry_select_inputs,
    output logic                    ready,
    output logic                    chain_busy_output,
    // Entry store
    output logic [ENTRY_W-1:0]      entry_addr,
    input  wire entry_t             entry_data,
    // Profile generator
    input  wire logic               op_done,
    input  wire logic               motor_stopped,
    output motion_cmd_t             motion_cmd
);

    // ==================================================================
    // State
    typedef struct packed {
        seq_state_t          st;
        logic [ENTRY_W-1:0]  cur;
        entry_t              ent;
        logic                have_prev;
        logic                prev_rev;
        logic                ready;
        logic                busy;
        logic                tmr_load;
        motion_cmd_t         cmd;
    } seq_t;

    seq_t s_q;
    seq_t s_d;
    logic tmr_expired;
    logic [ENTRY_W:0] nxt;

    delay_tick_timer u_timer (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .load    (s_q.tmr_load),
        .value   (s_q.ent.delay),
        .expired (tmr_expired)
    );

    // ==================================================================
    // Sequencing
    always_comb
    begin
        s_d = s_q;
        nxt = next_entry(s_q.cur, s_q.ent.next_num);
        s_d.tmr_load   = 1'b0;
        s_d.cmd.launch = 1'b0;
        unique case (s_q.st)
            ST_IDLE:
            begin
                // Ready also needs servo; dropping servo holds the block idle
                s_d.ready = servo_on;
                if (start && servo_on && s_q.ready)
                begin
                    s_d.cur       = entry_select_inputs; // see R15
                    s_d.ready     = 1'b0;                // see R03
                    s_d.busy      = 1'b1;
                    s_d.have_prev = 1'b0;
                    s_d.st        = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                // Entry data is valid this cycle for the address set last cycle
                s_d.ent          = entry_data;
                s_d.cmd.run      = 1'b1;
                s_d.cmd.launch   = 1'b1;
                s_d.cmd.entry    = s_q.cur;
                // Reversal after a continuous hand-over brakes on the new entry's
                // stopping rate; the motor passes the old target before turning.
                if (s_q.have_prev && (entry_data.reverse != s_q.prev_rev))
                begin
                    s_d.cmd.rate  = entry_data.stop_rate;   // see R09, R11
                    s_d.cmd.decel = 1'b1;
                end
                else
                begin
                    s_d.cmd.rate  = entry_data.accel_rate;  // see R08, R07
                    s_d.cmd.decel = 1'b0;
                end
                s_d.st = ST_MOVE;
            end
            ST_MOVE:
            begin
                if (op_done)
                begin
                    s_d.prev_rev  = s_q.ent.reverse;
                    s_d.have_prev = 1'b1;
                    if (s_q.ent.link == LINK_CONT && nxt[ENTRY_W])
                    begin
                        s_d.cur = nxt[ENTRY_W-1:0];         // see R06, R07
                        s_d.st  = ST_FETCH;
                    end
                    else if (s_q.ent.link == LINK_AUTO && nxt[ENTRY_W])
                    begin
                        s_d.cmd.run   = 1'b0;
                        s_d.cmd.rate  = s_q.ent.stop_rate;
                        s_d.cmd.decel = 1'b1;
                        s_d.have_prev = 1'b0;
                        s_d.tmr_load  = 1'b1;
                        s_d.st        = ST_DWELL;           // see R01
                    end
                    else
                    begin
                        // Manual linking is handled elsewhere; here it ends the chain
                        s_d.cmd.run   = 1'b0;
                        s_d.cmd.rate  = s_q.ent.stop_rate;  // see R10
                        s_d.cmd.decel = 1'b1;
                        s_d.st        = ST_STOP;            // see R02
                    end
                end
            end
            ST_DWELL:
            begin
                // One cycle after load the timer reflects the new count
                if (!s_q.tmr_load && tmr_expired && motor_stopped)
                begin
                    s_d.cur = nxt[ENTRY_W-1:0];             // see R01, R14
                    s_d.st  = ST_FETCH;
                end
            end
            ST_STOP:
            begin
                if (motor_stopped)
                begin
                    s_d.busy  = 1'b0;                       // see R05
                    s_d.ready = servo_on;
                    s_d.st    = ST_IDLE;
                end
            end
            default:
                s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q           <= '0;
            s_q.st        <= ST_IDLE;
            s_q.ent       <= ENTRY_RESET;                   // see R12, R13
        end
        else if (ce)
            s_q <= s_d;
    end

    assign ready             = s_q.ready;
    assign chain_busy_output = s_q.busy;
    assign entry_addr        = s_q.cur;
    assign motion_cmd        = s_q.cmd;

    // ==================================================================
    // Checks
    start_accept_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.st == ST_IDLE && start && servo_on && s_q.ready
        |=> !ready && chain_busy_output && entry_addr == $past(entry_select_inputs)) // see R03
        else $error("start not accepted correctly");

    latch_entry_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.st == ST_DWELL && !$changed(s_q.st) |-> $stable(entry_addr)) // see R15
        else $error("entry changed while dwelling");

    dwell_wait_a: assert property (@(posedge clk) disable iff (rst)
        s_q.st == ST_DWELL && !tmr_expired |=> s_q.st != ST_FETCH) // see R01
        else $error("next entry started before delay");

    chain_end_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.st == ST_MOVE && op_done && s_q.ent.link == LINK_NONE
        |=> s_q.st == ST_STOP && !motion_cmd.run) // see R02
        else $error("no-link entry did not stop chain");

    cont_flow_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.st == ST_MOVE && op_done && s_q.ent.link == LINK_CONT && nxt[ENTRY_W]
        |=> motion_cmd.run && s_q.st == ST_FETCH) // see R06
        else $error("continuous link stopped motor");

    accel_rate_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.st == ST_FETCH && !(s_q.have_prev && entry_data.reverse != s_q.prev_rev)
        |=> motion_cmd.rate == $past(entry_data.accel_rate)) // see R08
        else $error("wrong changing rate");

    reverse_rate_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.st == ST_FETCH && s_q.have_prev && entry_data.reverse != s_q.prev_rev
        |=> motion_cmd.decel && motion_cmd.rate == $past(entry_data.stop_rate)) // see R09
        else $error("wrong reversal rate");

    final_stop_a: assert property (@(posedge clk) disable iff (rst)
        s_q.st == ST_STOP |-> motion_cmd.rate == s_q.ent.stop_rate) // see R10
        else $error("wrong final stop rate");

    release_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.st == ST_STOP && motor_stopped |=> !chain_busy_output && ready == $past(servo_on)) // see R05
        else $error("chain end not released");

    // A stop code in the next-number field ends the chain whatever the link says
    stop_code_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.st == ST_MOVE && op_done && s_q.ent.next_num == NEXT_STOP
        |=> s_q.st == ST_STOP && !motion_cmd.run) // see R13
        else $error("stop code did not end chain");

    // The first dwell cycle still sees the old timer state, so it must not leave
    dwell_load_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.st == ST_DWELL && s_q.tmr_load |=> s_q.st == ST_DWELL) // see R14
        else $error("dwell left before timer load");

    select_hold_a: assert property (@(posedge clk) disable iff (rst)
        ce && (s_q.st == ST_FETCH || s_q.st == ST_STOP) |=> $stable(entry_addr)) // see R15
        else $error("entry address moved outside a chain step");

endmodule

// ---- verification/chain_partner.sv ----
// Far-side model: the operation-data store and a profile generator.
// Assumes the bench fills mem after reset; the generator reaches a target
// a few cycles after each launch and coasts to zero speed once run drops.
`timescale 1ns/1ps
module chain_partner
    import chain_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Entry store
    input  wire logic [ENTRY_W-1:0] entry_addr,
    output entry_t                  entry_data,
    // Profile generator
    input  wire motion_cmd_t        motion_cmd,
    output logic                    op_done,
    output logic                    motor_stopped
);
    entry_t     mem [256];
    logic [3:0] move_q;
    logic [3:0] speed_q;

    // Combinational read keeps the one-cycle answer with margin
    assign entry_data    = mem[entry_addr];
    assign motor_stopped = (speed_q == 4'h0);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            move_q  <= 4'h0;
            speed_q <= 4'h0;
            op_done <= 1'b0;
        end
        else
        begin
            op_done <= (move_q == 4'h1);
            if (motion_cmd.launch)
                move_q <= 4'h6;
            else if (move_q != 4'h0)
                move_q <= move_q - 4'h1;
            // Speed needs several cycles to decay, so a stop is never instant
            if (motion_cmd.run)
                speed_q <= 4'h5;
            else if (speed_q != 4'h0)
                speed_q <= speed_q - 4'h1;
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the chain sequencer: host handshake and chain runs.
// Assumes the partner model answers the entry store and profile generator.
`timescale 1ns/1ps
module tb_top
    import chain_pkg::*;
;
    logic               clk;
    logic               rst;
    logic               ce;
    logic               servo_on;
    logic               start;
    logic [ENTRY_W-1:0] sel;
    logic               ready;
    logic               busy;
    logic [ENTRY_W-1:0] entry_addr;
    entry_t             entry_data;
    logic               op_done;
    logic               motor_stopped;
    motion_cmd_t        cmd;
    int                 err_total;
    int                 cmp_count;
    int                 cyc;
    int                 run_falls;
    logic               run_prev;
    logic [RATE_W-1:0]  last_rate;
    logic [ENTRY_W-1:0] seen_entry [$];
    logic [RATE_W:0]    seen_rate [$];
    int                 launch_cyc [$];

    chain_sequencer dut (.clk(clk), .rst(rst), .ce(ce), .servo_on(servo_on),
        .start(start), .entry_select_inputs(sel), .ready(ready),
        .chain_busy_output(busy), .entry_addr(entry_addr), .entry_data(entry_data),
        .op_done(op_done), .motor_stopped(motor_stopped), .motion_cmd(cmd));
    chain_partner part (.clk(clk), .rst(rst), .entry_addr(entry_addr),
        .entry_data(entry_data), .motion_cmd(cmd), .op_done(op_done),
        .motor_stopped(motor_stopped));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ==========================================================
    // Monitor: launches, rates and stops seen at the generator
    always @(negedge clk)
    begin
        cyc = cyc + 1;
        if (cmd.launch === 1'b1)
        begin
            seen_entry.push_back(cmd.entry);
            seen_rate.push_back({cmd.decel, cmd.rate});
            launch_cyc.push_back(cyc);
        end
        if (run_prev === 1'b1 && cmd.run === 1'b0)
        begin
            run_falls = run_falls + 1;
            last_rate = cmd.rate;
        end
        run_prev = cmd.run;
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic put(input int n, input link_mode_t l, input logic [NEXT_W-1:0] nx,
                       input logic [DELAY_W-1:0] d, input logic [RATE_W-1:0] ar,
                       input logic [RATE_W-1:0] sr, input logic rv);
        part.mem[n] = '{l, nx, d, ar, sr, rv};
    endtask

    task automatic wait_ready(input logic lvl);
        int n;
        n = 0;
        while (ready !== lvl && n < 60000)
        begin
            @(negedge clk);
            n++;
        end
        check(32'(n < 60000), 32'h1);
    endtask

    // Host side of the handshake, then a scrambled select while the chain runs
    task automatic run_chain(input logic [ENTRY_W-1:0] n);
        seen_entry.delete();
        seen_rate.delete();
        launch_cyc.delete();
        run_falls = 0;
        wait_ready(1'b1);
        sel = n;
        start = 1'b1;
        wait_ready(1'b0);
        check(busy, 1'b1);
        start = 1'b0;
        sel = 8'hff;
        wait_ready(1'b1);
        check(busy, 1'b0);
    endtask

    task automatic expect_launch(input int k, input logic [ENTRY_W-1:0] e,
                                 input logic [RATE_W:0] r);
        check(seen_entry[k], e);
        check(seen_rate[k], r);
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        servo_on = 1'b0;
        start = 1'b0;
        sel = 8'h00;
        err_total = 0;
        cmp_count = 0;
        cyc = 0;
        run_falls = 0;
        run_prev = 1'b0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check(ready, 1'b0);
        start = 1'b1;
        repeat (4) @(negedge clk);
        check(busy, 1'b0);
        start = 1'b0;
        servo_on = 1'b1;
        put(0, LINK_AUTO, NEXT_PLUS_ONE, 24'h1, 16'h11, 16'h21, 1'b0);
        put(1, LINK_AUTO, 10'h003, 24'h0, 16'h12, 16'h22, 1'b0);
        put(3, LINK_NONE, NEXT_STOP, 24'h0, 16'h13, 16'h23, 1'b0);
        put(10, LINK_CONT, NEXT_PLUS_TWO, 24'h0, 16'h31, 16'h41, 1'b0);
        put(12, LINK_CONT, 10'h014, 24'h0, 16'h32, 16'h42, 1'b1);
        put(20, LINK_CONT, NEXT_STOP, 24'h0, 16'h33, 16'h43, 1'b1);
        put(50, LINK_MANUAL, NEXT_PLUS_ONE, 24'h0, 16'h51, 16'h61, 1'b0);
        put(51, LINK_NONE, NEXT_STOP, 24'h0, 16'h52, 16'h62, 1'b0);
        // Automatic chain with a one-tick dwell after the first entry
        run_chain(8'h00);
        check(seen_entry.size(), 3);
        expect_launch(0, 8'h00, 17'h00011);
        expect_launch(1, 8'h01, 17'h00012);
        expect_launch(2, 8'h03, 17'h00013);
        check(32'(launch_cyc[1] - launch_cyc[0] >= TICK_CYCLES), 1);
        check(32'(launch_cyc[1] - launch_cyc[0] < 2 * TICK_CYCLES), 1);
        check(run_falls, 3);
        check(last_rate, 16'h23);
        // Continuous chain: skip-one, explicit number, reversal, stop code
        run_chain(8'h0a);
        check(seen_entry.size(), 3);
        expect_launch(0, 8'h0a, 17'h00031);
        expect_launch(1, 8'h0c, 17'h10042);
        expect_launch(2, 8'h14, 17'h00033);
        check(run_falls, 1);
        check(last_rate, 16'h43);
        // Manual link ends the chain in this block
        run_chain(8'h32);
        check(seen_entry.size(), 1);
        expect_launch(0, 8'h32, 17'h00051);
        check(last_rate, 16'h61);
        // Clock enable low freezes ready even as servo drops and start comes
        ce = 1'b0;
        servo_on = 1'b0;
        start = 1'b1;
        repeat (3) @(negedge clk);
        check(ready, 1'b1);
        check(busy, 1'b0);
        start = 1'b0;
        ce = 1'b1;
        @(negedge clk);
        check(ready, 1'b0);
        servo_on = 1'b1;
        give_verdict();
    end

    // Longest run is one dwell tick plus short chains
    initial
    begin
        #(95000 * 25);
        err_total++;
        give_verdict();
    end
endmodule
